// File: inc/spd_pkg.sv
// spd_pkg: constants and carriers for the pin controlled power-down block
// assumes a single 10 MHz clock; all pins are sampled synchronously
// How it works
// - power-down only when option enabled, else plain pin
// - sleep pin high enters, low leaves power-down
// - outputs and internal state latched and held
// - outputs tri-stated at entry stay tri-stated
// - all inputs except sleep pin are blocked
// - pin keepers hold last pin levels while asleep
// - sleep pin array input unusable when option enabled
// - outputs valid again within 2 us after fall; the code takes RECOVER_CYC+1 = 21 cycles, 2.1 us
package spd_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SETUP_NS      = 10;
    localparam int unsigned DONTCARE_NS   = 5;
    localparam int unsigned RECOVER_US    = 2;
    // longest time rounds down, never below one cycle
    localparam int unsigned RECOVER_CYC_RAW =
        (RECOVER_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned RECOVER_CYC =
        (RECOVER_CYC_RAW < 1) ? 1 : RECOVER_CYC_RAW;
    localparam int unsigned IO_W  = 8;
    localparam int unsigned CNT_W = 8;

    typedef enum logic [1:0] {
        SPD_RUN   = 2'b00,
        SPD_SLEEP = 2'b01,
        SPD_WAKE  = 2'b10
    } spd_state_e;

    typedef struct packed {
        logic [IO_W-1:0] data;
        logic [IO_W-1:0] oe_n;
    } spd_pins_s;
endpackage : spd_pkg

// File: hdl/spd_hold_reg.sv
// spd_hold_reg: holding register for pin data and enables
// assumes load is low whenever the contents must be frozen
`timescale 1ns/10ps
module spd_hold_reg
    import spd_pkg::*;
#(
    parameter int unsigned W = 2*IO_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // control and data
    input  wire logic         load,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] mem_q;
    logic [W-1:0] mem_d;

    always_comb begin
        mem_d = load ? din : mem_q;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_q <= '0;
        end else begin
            mem_q <= mem_d;
        end
    end

    assign dout = mem_q;
endmodule : spd_hold_reg

// File: hdl/spd_power_down.sv
// spd_power_down: freezes user logic and pins while the sleep pin is high
// assumes user logic drives core_pins.data/core_pins.oe_n and obeys core_run
`timescale 1ns/10ps
module spd_power_down
    import spd_pkg::*;
#(
    parameter int unsigned RECOVER = RECOVER_CYC
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            arst_n,
    // configuration
    input  wire logic            pd_enable,
    // sleep pin as received
    input  wire logic            sleep_pin,
    // pins into the device
    input  wire logic [IO_W-1:0] pin_in,
    // user logic side
    input  wire spd_pins_s       core_pins,
    output spd_pins_s            pad_pins,
    output logic      [IO_W-1:0] core_in,
    output logic                 core_run,
    output logic                 sleep_array_in,
    output logic                 asleep,
    output logic                 outputs_valid
);
    spd_state_e       st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [IO_W-1:0]  keep_q, keep_d;
    logic [IO_W-1:0]  cin_q, cin_d;
    logic             run_q, run_d;
    logic             arr_q, arr_d;
    logic             slp_q, slp_d;
    logic             val_q, val_d;
    logic             hold_load;
    logic [2*IO_W-1:0] held;

    // pins are driven from held copies so they stay put in sleep
    assign hold_load = (st_d == SPD_RUN) && (st_q == SPD_RUN);

    spd_hold_reg #(.W(2*IO_W)) u_hold (
        .clk    (clk),
        .arst_n (arst_n),
        .load   (hold_load),
        .din    ({core_pins.oe_n, core_pins.data}),
        .dout   (held)
    );

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        keep_d = keep_q;
        cin_d  = cin_q;
        run_d  = run_q;
        arr_d  = pd_enable ? 1'b0 : sleep_pin;
        slp_d  = slp_q;
        val_d  = val_q;
        case (st_q)
            SPD_RUN: begin
                keep_d = pin_in;
                cin_d  = pin_in;
                if (pd_enable && sleep_pin) begin
                    st_d  = SPD_SLEEP;
                    run_d = 1'b0;
                    slp_d = 1'b1;
                    val_d = 1'b0;
                end else begin
                    run_d = 1'b1;
                end
            end
            SPD_SLEEP: begin
                // inputs blocked, keeper stays at last level
                cin_d = keep_q;
                if (!sleep_pin) begin
                    st_d  = SPD_WAKE;
                    cnt_d = CNT_W'(RECOVER - 1);
                    slp_d = 1'b0;
                end
            end
            SPD_WAKE: begin
                // a renewed rise during recovery returns to sleep
                if (sleep_pin && pd_enable) begin
                    st_d  = SPD_SLEEP;
                    slp_d = 1'b1;
                end else if (cnt_q == '0) begin
                    st_d  = SPD_RUN;
                    run_d = 1'b1;
                    val_d = 1'b1;
                    cin_d = pin_in;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            default: begin
                st_d = SPD_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q   <= SPD_RUN;
            cnt_q  <= '0;
            keep_q <= '0;
            cin_q  <= '0;
            run_q  <= 1'b1;
            arr_q  <= 1'b0;
            slp_q  <= 1'b0;
            val_q  <= 1'b1;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            keep_q <= keep_d;
            cin_q  <= cin_d;
            run_q  <= run_d;
            arr_q  <= arr_d;
            slp_q  <= slp_d;
            val_q  <= val_d;
        end
    end

    // held enables keep tri-stated outputs tri-stated
    assign pad_pins.data  = held[IO_W-1:0];
    assign pad_pins.oe_n  = held[2*IO_W-1:IO_W];
    assign core_in        = cin_q;
    assign core_run       = run_q;
    assign sleep_array_in = arr_q;
    assign asleep         = slp_q;
    assign outputs_valid  = val_q;
endmodule : spd_power_down

// File: verif/spd_props.sv
// spd_props: port checks for the power-down block
// assumes the bind below reaches every instance
`timescale 1ns/10ps
module spd_props
    import spd_pkg::*;
#(parameter int RECOVER = 3) (
    input wire logic clk, arst_n, pd_enable, sleep_pin, asleep,
    input wire logic core_run, outputs_valid, sleep_array_in,
    input wire logic [IO_W-1:0] core_in,
    input wire spd_pins_s pad_pins
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    enter_a: assert property (pd_enable && sleep_pin |=> asleep)
        else $error("no entry");
    leave_a: assert property (asleep && !sleep_pin |=> !asleep)
        else $error("no exit");
    pad_hold_a: assert property (asleep |=> $stable(pad_pins))
        else $error("pad moved");
    in_block_a: assert property (asleep |=> $stable(core_in))
        else $error("input leaked");
    frozen_a: assert property (asleep |-> !core_run && !outputs_valid)
        else $error("core ran");
    array_off_a: assert property (pd_enable |=> !sleep_array_in)
        else $error("array input");
    recover_a: assert property ($rose(outputs_valid)
        |-> $past(asleep, RECOVER+1) && !$past(asleep, RECOVER))
        else $error("recovery time");
    resume_a: assert property ($rose(core_run) |-> $stable(pad_pins))
        else $error("state reset");
endmodule : spd_props
bind spd_power_down spd_props #(.RECOVER(RECOVER)) u_spd_props (.*);

// File: verif/spd_far_side.sv
// spd_far_side: system logic on the sleep and input pins
// assumes the bench sets req and d off the rising edge
`timescale 1ns/10ps
module spd_far_side
    import spd_pkg::*;
(
    input  wire logic            clk, req,
    input  wire logic [IO_W-1:0] d,
    output logic                 sleep_pin = 1'b0,
    output logic      [IO_W-1:0] pin_in = 8'h00
);
    // pins held through the rise, then wander since they are ignored
    always @(posedge clk) begin
        sleep_pin <= req;
        pin_in <= sleep_pin ? ~d : d;
    end
endmodule : spd_far_side

// File: verif/tb_top.sv
// tb_top: directed runs of the power-down block
// assumes spd_far_side drives the pins, checker bound
`timescale 1ns/10ps
module tb_top import spd_pkg::*; ;
    logic clk = 1'b0, arst_n = 1'b0, pd_enable = 1'b0, req = 1'b0;
    logic sleep_pin, asleep, core_run, outputs_valid, sleep_array_in;
    logic [IO_W-1:0] d = 8'h5a, pin_in, core_in;
    spd_pins_s core_pins = 16'h0000, pad_pins;
    int num_errors = 0, n_checks = 0, cyc = 0, n = 0;
    always #50 clk = ~clk;
    spd_far_side u_spd_far_side (.*);
    spd_power_down #(.RECOVER(3)) u_spd_power_down (.*);
    task automatic chk(string s, logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic wait_n(int k);
        repeat (k) @(negedge clk);
    endtask : wait_n
    always @(posedge clk) if (++cyc > 300) begin
        num_errors++;
        stop_test();
    end
    task automatic t_plain();
        req = 1'b1;
        wait_n(4);
        chk("asleep", 16'h0000, 16'(asleep));
        chk("core_in", 16'h00a5, 16'(core_in));
        chk("array_in", 16'h0001, 16'(sleep_array_in));
        req = 1'b0;
        wait_n(2);
    endtask : t_plain
    task automatic t_sleep();
        pd_enable = 1'b1;
        core_pins = 16'h96f0;
        wait_n(3);
        req = 1'b1;
        wait_n(2);
        core_pins = 16'h1100;
        wait_n(4);
        chk("pad", 16'h96f0, pad_pins);
        chk("core_in", 16'h005a, 16'(core_in));
        chk("asleep", 16'h0001, 16'(asleep));
        chk("core_run", 16'h0000, 16'(core_run));
        chk("valid", 16'h0000, 16'(outputs_valid));
        chk("array_in", 16'h0000, 16'(sleep_array_in));
        req = 1'b0;
        for (n = 0; outputs_valid !== 1'b1 && n < 50; n++) wait_n(1);
        // two edges through the pin and state, then three of recovery
        chk("wake", 16'h0005, 16'(n));
        chk("pad", 16'h96f0, pad_pins);
        chk("core_run", 16'h0001, 16'(core_run));
    endtask : t_sleep
    initial begin
        wait_n(8);
        arst_n = 1'b1;
        t_plain();
        t_sleep();
        stop_test();
    end
endmodule : tb_top
